// file: src/rwc_rotate_unit.sv
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module rwc_rotate_unit (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic opValid,
  input wire logic [rwc_pkg::SEL_W-1:0] opSelect,
  input wire logic [rwc_pkg::FILE_AW-1:0] opAddr,
  input wire logic opIndirect,
  input wire logic opCarryIn,
  output logic opDone,
  output logic opError,
  output logic [rwc_pkg::WORD_W-1:0] resultData,
  output logic [rwc_pkg::BYTE_W-1:0] flagsOut,
  input wire logic [rwc_pkg::BUS_AW-1:0] regAddr,
  input wire logic [rwc_pkg::BYTE_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [rwc_pkg::BYTE_W-1:0] regRdData
);
  import rwc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rstSync1_ff;
  logic rstSync2_ff;
  logic rstLocal_n;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1_ff <= 1'b0;
      rstSync2_ff <= 1'b0;
    end else begin
      rstSync1_ff <= 1'b1;
      rstSync2_ff <= rstSync1_ff;
    end
  end

  assign rstLocal_n = rstSync2_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Operation decode

  rwc_op_t opCode;
  logic selLegal;
  logic isWordOp;
  logic execute;

  always_comb begin
    opCode = RWC_OP_NONE;
    selLegal = 1'b1;
    case (opSelect)
      6'h01: begin
        opCode = RWC_OP_BYTE_LEFT_THROUGH_FLAG;
      end
      6'h02: begin
        opCode = RWC_OP_WORD_LEFT_THROUGH_FLAG;
      end
      6'h04: begin
        opCode = RWC_OP_BYTE_CIRCULAR_LEFT;
      end
      6'h08: begin
        opCode = RWC_OP_BYTE_CIRCULAR_RIGHT;
      end
      6'h10: begin
        opCode = RWC_OP_BYTE_RIGHT_THROUGH_FLAG;
      end
      6'h20: begin
        opCode = RWC_OP_WORD_RIGHT_THROUGH_FLAG;
      end
      default: begin
        selLegal = 1'b0;
      end
    endcase
  end

  assign isWordOp = opSelect[SEL_WORD_LEFT_THROUGH]
                  | opSelect[SEL_WORD_RIGHT_THROUGH];
  assign execute = opValid & selLegal;

  ////////////////////////////////////////////////////////////////////////////
  // Register file and operand fetch

  logic [7:0] fileMem_ff [FILE_DEPTH];
  logic [FILE_AW-1:0] effAddr;
  logic [FILE_AW-1:0] hiAddr;
  logic [FILE_AW-1:0] loAddr;
  logic [15:0] operand;
  logic [15:0] rotResult;
  logic rotCarry;
  logic rotZero;
  logic rotZeroValid;
  logic rotSign;
  logic rotOver;

  // For byte ops, pointer mode takes the target address from the named register; word ops ignore it
  always_comb begin
    if (opIndirect && !isWordOp) begin
      effAddr = fileMem_ff[opAddr][FILE_AW-1:0];
    end else begin
      effAddr = opAddr;
    end
  end

  // Pairs start on an even register, high byte first
  assign hiAddr = {effAddr[FILE_AW-1:1], 1'b0};
  assign loAddr = {effAddr[FILE_AW-1:1], 1'b1};

  always_comb begin
    if (isWordOp) begin
      operand = {fileMem_ff[hiAddr], fileMem_ff[loAddr]};
    end else begin
      operand = {8'h00, fileMem_ff[effAddr]};
    end
  end

  rwc_rotate_core uCore (
    .op(opCode),
    .operand(operand),
    .carryIn(opCarryIn),
    .result(rotResult),
    .carryOut(rotCarry),
    .zeroOut(rotZero),
    .zeroValid(rotZeroValid),
    .signOut(rotSign),
    .overOut(rotOver)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register file write-back; instruction wins over software

  logic swFileWr;

  assign swFileWr = regWrEn & (regAddr[7:FILE_AW] == ADDR_FILE_BASE[7:FILE_AW]);

  generate
    for (genvar i = 0; i < FILE_DEPTH; i++) begin : gFile
      logic hitByte;
      logic hitHi;
      logic hitLo;

      assign hitByte = execute & !isWordOp & (effAddr == FILE_AW'(i));
      assign hitHi = execute & isWordOp & (hiAddr == FILE_AW'(i));
      assign hitLo = execute & isWordOp & (loAddr == FILE_AW'(i));

      always_ff @(posedge ref_clk or negedge rstLocal_n) begin
        if (!rstLocal_n) begin
          fileMem_ff[i] <= FILE_RESET;
        end else if (hitByte) begin
          fileMem_ff[i] <= rotResult[7:0];
        end else if (hitHi) begin
          fileMem_ff[i] <= rotResult[15:8];
        end else if (hitLo) begin
          fileMem_ff[i] <= rotResult[7:0];
        end else if (swFileWr && (regAddr[FILE_AW-1:0] == FILE_AW'(i))) begin
          fileMem_ff[i] <= regWrData;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Flags

  logic [7:0] flags_ff;
  logic [7:0] nxt_flags;

  always_comb begin
    nxt_flags = flags_ff;
    if (regWrEn && (regAddr == ADDR_FLAGS)) begin
      nxt_flags = regWrData & FLAG_MASK;
    end
    if (execute) begin
      nxt_flags[FLAG_C] = rotCarry;
      nxt_flags[FLAG_S] = rotSign;
      nxt_flags[FLAG_V] = rotOver;
      if (rotZeroValid) begin
        nxt_flags[FLAG_Z] = rotZero;
      end
      nxt_flags[FLAG_D] = flags_ff[FLAG_D];
      nxt_flags[FLAG_H] = flags_ff[FLAG_H];
    end
  end

  always_ff @(posedge ref_clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      flags_ff <= FLAGS_RESET;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result and completion

  logic [15:0] result_ff;
  logic done_ff;
  logic errPulse_ff;

  always_ff @(posedge ref_clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      result_ff <= 16'h0000;
      done_ff <= 1'b0;
      errPulse_ff <= 1'b0;
    end else begin
      done_ff <= execute;
      errPulse_ff <= opValid & !selLegal;
      if (execute) begin
        result_ff <= rotResult;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status: sticky error, last operation, operation count

  logic errSticky_ff;
  logic [2:0] lastOp_ff;
  logic [7:0] opCount_ff;
  logic errClear;

  assign errClear = regWrEn & (regAddr == ADDR_STATUS) & regWrData[STAT_ERR];

  always_ff @(posedge ref_clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      errSticky_ff <= 1'b0;
    end else if (opValid && !selLegal) begin
      errSticky_ff <= 1'b1;
    end else if (errClear) begin
      errSticky_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      lastOp_ff <= 3'b000;
    end else if (execute) begin
      lastOp_ff <= opCode;
    end
  end

  always_ff @(posedge ref_clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      opCount_ff <= 8'h00;
    end else if (execute) begin
      opCount_ff <= opCount_ff + 8'h01;
    end else if (regWrEn && (regAddr == ADDR_OP_COUNT)) begin
      opCount_ff <= regWrData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port

  logic [7:0] rdData_ff;
  logic [7:0] nxt_rdData;
  logic [7:0] statusWord;

  always_comb begin
    statusWord = STATUS_RESET;
    statusWord[STAT_ERR] = errSticky_ff;
    statusWord[STAT_OP_LSB +: 3] = lastOp_ff;
  end

  always_comb begin
    nxt_rdData = 8'h00;
    if (regAddr[7:FILE_AW] == ADDR_FILE_BASE[7:FILE_AW]) begin
      nxt_rdData = fileMem_ff[regAddr[FILE_AW-1:0]];
    end else begin
      case (regAddr)
        ADDR_FLAGS: begin
          nxt_rdData = flags_ff;
        end
        ADDR_STATUS: begin
          nxt_rdData = statusWord;
        end
        ADDR_RESULT_HI: begin
          nxt_rdData = result_ff[15:8];
        end
        ADDR_RESULT_LO: begin
          nxt_rdData = result_ff[7:0];
        end
        ADDR_OP_COUNT: begin
          nxt_rdData = opCount_ff;
        end
        default: begin
          nxt_rdData = 8'h00;
        end
      endcase
    end
  end

  // Data only valid the cycle after the strobe; zero otherwise
  always_ff @(posedge ref_clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      rdData_ff <= 8'h00;
    end else if (regRdEn) begin
      rdData_ff <= nxt_rdData;
    end else begin
      rdData_ff <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign opDone = done_ff;
  assign opError = errPulse_ff;
  assign resultData = result_ff;
  assign flagsOut = flags_ff;
  assign regRdData = rdData_ff;

endmodule
`default_nettype wire

// file: src/rwc_pkg.sv
package rwc_pkg;

  localparam int unsigned BYTE_W = 8;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned FILE_DEPTH = 16;
  localparam int unsigned FILE_AW = 4;
  localparam int unsigned BUS_AW = 8;
  localparam int unsigned SEL_W = 6;

  // One-hot operation select positions
  localparam int unsigned SEL_BYTE_LEFT_THROUGH = 0;
  localparam int unsigned SEL_WORD_LEFT_THROUGH = 1;
  localparam int unsigned SEL_BYTE_CIRC_LEFT = 2;
  localparam int unsigned SEL_BYTE_CIRC_RIGHT = 3;
  localparam int unsigned SEL_BYTE_RIGHT_THROUGH = 4;
  localparam int unsigned SEL_WORD_RIGHT_THROUGH = 5;

  typedef enum logic [2:0] {
    RWC_OP_NONE = 3'b000,
    RWC_OP_BYTE_LEFT_THROUGH_FLAG = 3'b001,
    RWC_OP_WORD_LEFT_THROUGH_FLAG = 3'b010,
    RWC_OP_BYTE_CIRCULAR_LEFT = 3'b011,
    RWC_OP_BYTE_CIRCULAR_RIGHT = 3'b100,
    RWC_OP_BYTE_RIGHT_THROUGH_FLAG = 3'b101,
    RWC_OP_WORD_RIGHT_THROUGH_FLAG = 3'b110
  } rwc_op_t;

  // Flag register bit positions
  localparam int unsigned FLAG_C = 7;
  localparam int unsigned FLAG_Z = 6;
  localparam int unsigned FLAG_S = 5;
  localparam int unsigned FLAG_V = 4;
  localparam int unsigned FLAG_D = 3;
  localparam int unsigned FLAG_H = 2;
  localparam logic [7:0] FLAG_MASK = 8'hFC;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // Register map: file bytes at 0x00..0x0F
  localparam logic [7:0] ADDR_FILE_BASE = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h11;
  localparam logic [7:0] ADDR_RESULT_HI = 8'h12;
  localparam logic [7:0] ADDR_RESULT_LO = 8'h13;
  localparam logic [7:0] ADDR_OP_COUNT = 8'h14;

  // Status register fields
  localparam int unsigned STAT_ERR = 7;
  localparam int unsigned STAT_OP_LSB = 0;
  localparam logic [7:0] FILE_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;

endpackage

// file: src/rwc_rotate_core.sv
`timescale 1ns/100ps
`default_nettype none

module rwc_rotate_core (
  input wire rwc_pkg::rwc_op_t op,
  input wire logic [15:0] operand,
  input wire logic carryIn,
  output logic [15:0] result,
  output logic carryOut,
  output logic zeroOut,
  output logic zeroValid,
  output logic signOut,
  output logic overOut
);
  import rwc_pkg::*;

  logic [7:0] lowByte;
  logic [7:0] resByte;

  assign lowByte = operand[7:0];

  always_comb begin
    resByte = lowByte;
    result = operand;
    carryOut = carryIn;
    zeroValid = 1'b1;
    case (op)
      RWC_OP_BYTE_LEFT_THROUGH_FLAG: begin
        resByte = {lowByte[6:0], carryIn};
        carryOut = lowByte[7];
      end
      RWC_OP_BYTE_CIRCULAR_LEFT: begin
        resByte = {lowByte[6:0], lowByte[7]};
        carryOut = lowByte[7];
      end
      RWC_OP_BYTE_CIRCULAR_RIGHT: begin
        resByte = {lowByte[0], lowByte[7:1]};
        carryOut = lowByte[0];
      end
      RWC_OP_BYTE_RIGHT_THROUGH_FLAG: begin
        resByte = {carryIn, lowByte[7:1]};
        carryOut = lowByte[0];
      end
      RWC_OP_WORD_LEFT_THROUGH_FLAG: begin
        result = {operand[14:0], carryIn};
        carryOut = operand[15];
        zeroValid = 1'b0;
      end
      RWC_OP_WORD_RIGHT_THROUGH_FLAG: begin
        result = {carryIn, operand[15:1]};
        carryOut = operand[0];
        zeroValid = 1'b0;
      end
      default: begin
        resByte = lowByte;
      end
    endcase
    if (zeroValid) begin
      result = {8'h00, resByte};
    end
  end

  always_comb begin
    if (zeroValid) begin
      zeroOut = (result[7:0] == 8'h00);
      signOut = result[7];
      overOut = result[7] ^ operand[7];
    end else begin
      zeroOut = 1'b0;
      signOut = result[15];
      overOut = result[15] ^ operand[15];
    end
  end

endmodule
`default_nettype wire

// file: tb/rwc_rotate_unit_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module rwc_rotate_unit_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic opValid,
  input wire logic [rwc_pkg::SEL_W-1:0] opSelect,
  input wire logic opCarryIn,
  input wire logic opDone,
  input wire logic opError,
  input wire logic [rwc_pkg::WORD_W-1:0] resultData,
  input wire logic [rwc_pkg::BYTE_W-1:0] flagsOut
);
  import rwc_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic legal;
  logic wordOp;
  assign legal = opValid && $onehot(opSelect);
  assign wordOp = opSelect[1] || opSelect[5];
  //////////////////////////////////////////////////////////////////////////
  done_pulse_a: assert property (legal |=> opDone && !opError)
    else $error("no done pulse after a legal op");
  error_pulse_a: assert property (opValid && !legal |=> opError && !opDone)
    else $error("no error pulse after a bad select");
  blt_shift_a: assert property (opValid && opSelect == 6'h01 |=>
    resultData[0] == $past(opCarryIn) && resultData[15:8] == 8'h00
    && flagsOut[4] == (resultData[7] ^ flagsOut[7]))
    else $error("byte left through carry wrong");
  wlt_shift_a: assert property (opValid && opSelect == 6'h02 |=>
    resultData[0] == $past(opCarryIn)
    && flagsOut[4] == (resultData[15] ^ flagsOut[7]))
    else $error("word left through carry wrong");
  bcl_wrap_a: assert property (opValid && opSelect == 6'h04 |=>
    resultData[0] == flagsOut[7]
    && flagsOut[4] == (resultData[7] ^ flagsOut[7]))
    else $error("byte circular left wrong");
  bcr_wrap_a: assert property (opValid && opSelect == 6'h08 |=>
    resultData[7] == flagsOut[7]
    && flagsOut[4] == (resultData[7] ^ resultData[6]))
    else $error("byte circular right wrong");
  brt_shift_a: assert property (opValid && opSelect == 6'h10 |=>
    resultData[7] == $past(opCarryIn)
    && flagsOut[4] == (resultData[7] ^ resultData[6]))
    else $error("byte right through carry wrong");
  wrt_shift_a: assert property (opValid && opSelect == 6'h20 |=>
    resultData[15] == $past(opCarryIn)
    && flagsOut[4] == (resultData[15] ^ resultData[14]))
    else $error("word right through carry wrong");
  byte_zs_a: assert property (legal && !wordOp |=>
    flagsOut[6] == (resultData[7:0] == 8'h00) && flagsOut[5] == resultData[7])
    else $error("byte zero or sign wrong");
  word_zs_a: assert property (legal && wordOp |=>
    $stable(flagsOut[6]) && flagsOut[5] == resultData[15])
    else $error("word zero or sign wrong");
  keep_dh_a: assert property (legal |=> $stable(flagsOut[3:2]))
    else $error("decimal or half carry disturbed");
endmodule
bind rwc_rotate_unit rwc_rotate_unit_checker chk (.ref_clk, .rst_n,
  .opValid, .opSelect, .opCarryIn, .opDone, .opError, .resultData,
  .flagsOut);
`default_nettype wire

// file: tb/rwc_decoder_model.sv
`timescale 1ns/100ps
`default_nettype none
module rwc_decoder_model (
  input wire logic ref_clk,
  output logic opValid,
  output logic [rwc_pkg::SEL_W-1:0] opSelect,
  output logic [rwc_pkg::FILE_AW-1:0] opAddr,
  output logic opIndirect,
  output logic opCarryIn
);
  import rwc_pkg::*;
  initial begin
    opValid = 1'b0;
    opSelect = 6'h00;
    opAddr = 4'h0;
    opIndirect = 1'b0;
    opCarryIn = 1'b0;
  end
  // One instruction per call; caller sits just past an edge
  task automatic issue(input logic [5:0] s, input logic [3:0] a,
                       input logic i, input logic c);
    opValid <= 1'b1;
    opSelect <= s;
    opAddr <= a;
    opIndirect <= i;
    opCarryIn <= c;
    @(posedge ref_clk);
  endtask
  // Fields are meaningless between instructions, so scramble them
  task automatic idle();
    opValid <= 1'b0;
    opSelect <= ~opSelect;
    opAddr <= ~opAddr;
    opIndirect <= ~opIndirect;
    opCarryIn <= ~opCarryIn;
  endtask
endmodule
`default_nettype wire

// file: tb/rotate_unit_with_carry_test.sv
`timescale 1ns/100ps
`default_nettype none
module rotate_unit_with_carry_test;
  import rwc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic opValid, opIndirect, opCarryIn, opDone, opError;
  logic [SEL_W-1:0] opSelect;
  logic [FILE_AW-1:0] opAddr;
  logic [WORD_W-1:0] resultData;
  logic [BYTE_W-1:0] flagsOut, regRdData, flg, d;
  logic [BYTE_W-1:0] regWrData = 8'h00;
  logic [BUS_AW-1:0] regAddr = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] mem [16];
  logic [3:0] a;
  int failures = 0;
  int n_checks = 0;
  always #5 ref_clk = ~ref_clk;
  rwc_rotate_unit dut (.ref_clk, .rst_n, .opValid, .opSelect, .opAddr,
    .opIndirect, .opCarryIn, .opDone, .opError, .resultData, .flagsOut,
    .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData);
  rwc_decoder_model dec (.ref_clk, .opValid, .opSelect, .opAddr,
    .opIndirect, .opCarryIn);
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string w, input logic [15:0] got,
                       input logic [15:0] e);
    n_checks++;
    if (got !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", w, e, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] v);
    regAddr <= ad;
    regWrData <= v;
    regWrEn <= 1'b1;
    regRdEn <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rdchk(input logic [7:0] ad, input logic [7:0] e,
                       input string w);
    regAddr <= ad;
    regRdEn <= 1'b1;
    regWrEn <= 1'b0;
    @(posedge ref_clk);
    regRdEn <= 1'b0;
    #1 check(w, {8'h00, regRdData}, {8'h00, e});
    @(posedge ref_clk);
  endtask
  // Result in [23:8], new flags in [7:0]
  function automatic logic [23:0] rot(int k, logic [15:0] v, logic c,
                                      logic [7:0] f);
    logic [15:0] r;
    logic w;
    w = (k == 1 || k == 5);
    case (k)
      0: r = {8'h00, v[6:0], c};
      1: r = {v[14:0], c};
      2: r = {8'h00, v[6:0], v[7]};
      3: r = {8'h00, v[0], v[7:1]};
      4: r = {8'h00, c, v[7:1]};
      default: r = {c, v[15:1]};
    endcase
    f[FLAG_C] = (k == 0 || k == 2) ? v[7] : (k == 1) ? v[15] : v[0];
    f[FLAG_S] = w ? r[15] : r[7];
    f[FLAG_V] = w ? r[15] ^ v[15] : r[7] ^ v[7];
    if (!w) begin
      f[FLAG_Z] = (r[7:0] == 8'h00);
    end
    return {r, f};
  endfunction
  task automatic op(input int k, input logic [3:0] ad, input logic i,
                    input logic c, input logic chk);
    logic [3:0] p;
    logic [15:0] v;
    logic [23:0] e;
    logic w;
    w = (k == 1 || k == 5);
    p = (i && !w) ? mem[ad][3:0] : ad;
    v = w ? {mem[{ad[3:1], 1'b0}], mem[{ad[3:1], 1'b1}]} : {8'h00, mem[p]};
    e = rot(k, v, c, flg);
    if (w) begin
      {mem[{ad[3:1], 1'b0}], mem[{ad[3:1], 1'b1}]} = e[23:8];
    end else begin
      mem[p] = e[15:8];
    end
    flg = e[7:0];
    regWrEn <= 1'b0;
    regRdEn <= 1'b0;
    dec.issue(6'(1 << k), ad, i, c);
    if (chk) begin
      dec.idle();
      #1 check("done", {15'h0000, opDone}, 16'h0001);
      check("result", resultData, e[23:8]);
      check("flags", {8'h00, flagsOut}, {8'h00, flg});
      @(posedge ref_clk);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    failures++;
    wrap_up();
  end
  initial begin
    void'($urandom(7079));
    for (int i = 0; i < 16; i++) begin
      mem[i] = 8'h00;
    end
    flg = 8'h00;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rdchk(ADDR_FLAGS, 8'h00, "flags reset");
    rdchk(ADDR_STATUS, 8'h00, "status reset");
    wr(8'h03, 8'hCC);
    mem[3] = 8'hCC;
    op(0, 4'h3, 1'b0, 1'b0, 1'b1);
    regWrEn <= 1'b0;
    dec.issue(6'h03, 4'h3, 1'b0, 1'b1);
    dec.idle();
    #1 check("error", {15'h0000, opError}, 16'h0001);
    check("flags kept", {8'h00, flagsOut}, {8'h00, flg});
    @(posedge ref_clk);
    rdchk(ADDR_STATUS, 8'h81, "status");
    wr(ADDR_STATUS, 8'h80);
    rdchk(ADDR_STATUS, 8'h01, "status clear");
    wr(8'h3F, 8'hA5);
    rdchk(8'h3F, 8'h00, "unmapped");
    for (int k = 0; k < 6; k++) begin
      wr(8'h00, 8'h80);
      wr(8'h01, 8'h01);
      mem[0] = 8'h80;
      mem[1] = 8'h01;
      op(k, 4'h0, 1'b0, 1'(k), 1'b1);
    end
    // Last op was word right through carry on 16'h8001 with carry set
    rdchk(ADDR_RESULT_HI, 8'hC0, "result hi");
    rdchk(ADDR_RESULT_LO, 8'h00, "result lo");
    rdchk(ADDR_OP_COUNT, 8'h07, "op count");
    repeat (150) begin
      a = 4'($urandom);
      d = 8'($urandom);
      wr({4'h0, a}, d);
      mem[a] = d;
      d = 8'($urandom);
      wr(ADDR_FLAGS, d);
      flg = d & FLAG_MASK;
      if ($urandom_range(1) == 1) begin
        op($urandom_range(5), 4'($urandom), 1'($urandom), 1'($urandom), 1'b0);
      end
      op($urandom_range(5), 4'($urandom), 1'($urandom), 1'($urandom), 1'b1);
    end
    for (int i = 0; i < 16; i++) begin
      rdchk(8'(i), mem[i], "file byte");
    end
    rdchk(ADDR_FLAGS, flg, "flags reg");
    wrap_up();
  end
endmodule
`default_nettype wire
